// >>> rtl/txmux_map.vh
`ifndef TXMUX_MAP_VH
`define TXMUX_MAP_VH
// Operating modes when the add bus is disabled.
`define TXMUX_MODE_HDLC 1'b0
`define TXMUX_MODE_CLEAR 1'b1
// Position of the shared pin within the byte buses.
`define TXMUX_BIT_IDX 3'h6
// Byte-rate clock divider: half period of the HDLC byte clock in cycles of clk_in.
`define TXMUX_HDLC_HALF 8'h04
// Overhead spacing in payload bits (clear-channel mode).
`define TXMUX_OH_PERIOD 8'h54
`define TXMUX_FIFO_AW 2
`define TXMUX_FIFO_DEPTH 4
`endif

// >>> rtl/txmux_fifo.v
`default_nettype none
module txmux_fifo #(
  parameter WIDTH = 2,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire clk_in,
  input wire reset_in,
  input wire in_valid_in,
  output wire in_ready_out,
  input wire [WIDTH-1:0] in_data_in,
  output wire out_valid_out,
  input wire out_ready_in,
  output wire [WIDTH-1:0] out_data_out
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_r;
  reg [AW-1:0] rd_ptr_r;
  reg [AW:0] count_r;
  wire push;
  wire pop;
  assign in_ready_out = (count_r != DEPTH[AW:0]);
  assign out_valid_out = (count_r != {(AW+1){1'b0}});
  assign out_data_out = mem_r[rd_ptr_r];
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;
  always @(posedge clk_in)
  begin
    if (push)
    begin
      mem_r[wr_ptr_r] <= in_data_in;
    end
  end
  always @(posedge clk_in)
  begin
    if (reset_in)
    begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
      begin
        wr_ptr_r <= (wr_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_r <= (rd_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
      end
      if (push & ~pop)
      begin
        count_r <= count_r + 1'b1;
      end
      else if (pop & ~push)
      begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule // txmux_fifo
`default_nettype wire

// >>> rtl/txmux_top.v
// Behaviour
// - The add-bus enable picks the pin role first; otherwise the operating mode picks HDLC byte or serial payload.
// - With the add bus on, the pin is bit 6 of the add bus and is latched on the falling add-bus clock edge.
// - In HDLC mode the pin is bit 6 of the byte-wide transmit input bus, bits 7 down to 0.
// - In HDLC mode the block drives a byte-rate transmit clock out to the terminal equipment.
// - In HDLC mode the pin and the other seven byte bits are sampled on the rising edge of that clock output.
// - In clear-channel mode the pin is sampled on each rising edge of the payload input clock.
// - In clear-channel mode an overhead warning pulses two bits early; the next bit is still taken and the one after it is ignored.
`default_nettype none
`include "txmux_map.vh"
module txmux_top #(
  parameter OH_PERIOD = `TXMUX_OH_PERIOD,
  parameter HDLC_HALF = `TXMUX_HDLC_HALF
) (
  input wire clk_in,
  input wire reset_in,
  input wire add_bus_enable_in,
  input wire clear_mode_in,
  input wire add_bus_ch2_clock,
  input wire [7:0] add_bus_ch2_in,
  input wire [7:0] hdlc_tx_byte_ch2_in,
  input wire payload_in_clock,
  input wire data_ready_in,
  output reg hdlc_tx_byte_clock_ch2_out,
  output reg overhead_warn_out,
  output reg data_valid_out,
  output reg [1:0] data_kind_out,
  output reg [7:0] data_byte_out
);
  // Kind codes as shown on the data kind output.
  localparam KIND_ADD = 2'h0;
  localparam KIND_HDLC = 2'h1;
  localparam KIND_SERIAL = 2'h2;
  reg [7:0] add_s1_r;
  reg [7:0] add_s2_r;
  reg [7:0] hd_s1_r;
  reg [7:0] hd_s2_r;
  reg [1:0] ck_s1_r;
  reg [1:0] ck_s2_r;
  reg [1:0] ck_prev_r;
  reg [1:0] cfg_s1_r;
  reg [1:0] cfg_s2_r;
  reg [7:0] div_r;
  reg [7:0] oh_cnt_r;
  reg [7:0] ser_sh_r;
  reg [2:0] ser_cnt_r;
  reg oh_skip_r;
  reg [9:0] f_in_data;
  reg f_in_valid;
  wire f_in_ready;
  wire f_out_valid;
  wire [9:0] f_out_data;
  wire add_fall;
  wire pay_rise;
  wire hdlc_rise;
  wire [7:0] ser_nxt;
  reg [1:0] mode_sel;
  // Pin role select. The role straps pass the same two stages as the pins; a role change is
  // only clean while reset is held, since words already buffered keep the kind they were taken with.
  // add bus wins, then mode
  always @*
  begin
    if (cfg_s2_r[0])
    begin
      mode_sel = KIND_ADD;
    end
    else if (cfg_s2_r[1] == `TXMUX_MODE_CLEAR)
    begin
      mode_sel = KIND_SERIAL;
    end
    else
    begin
      mode_sel = KIND_HDLC;
    end
  end
  // Edges are found on the second synchroniser stage, so every pin edge is acted on about three
  // cycles late; the data buses pass the same two stages and so stay aligned with the edges.
  // falling add clock edge
  assign add_fall = ck_prev_r[0] & ~ck_s2_r[0];
  assign pay_rise = ~ck_prev_r[1] & ck_s2_r[1];
  // The byte taken at the rising edge of the byte clock is the bus as it stood two cycles earlier;
  // the terminal changes it at the falling edge, half a byte period before, so the lag is harmless.
  // rising edge of own clock
  assign hdlc_rise = (div_r == HDLC_HALF - 8'h01) & ~hdlc_tx_byte_clock_ch2_out;
  assign ser_nxt = {ser_sh_r[6:0], add_s2_r[`TXMUX_BIT_IDX]};
  // Two-stage synchronisers for everything from the terminal side; unreset, they flush in two cycles.
  always @(posedge clk_in)
  begin
    cfg_s1_r <= {clear_mode_in, add_bus_enable_in};
    cfg_s2_r <= cfg_s1_r;
    add_s1_r <= add_bus_ch2_in;
    add_s2_r <= add_s1_r;
    hd_s1_r <= hdlc_tx_byte_ch2_in;
    hd_s2_r <= hd_s1_r;
    ck_s1_r <= {payload_in_clock, add_bus_ch2_clock};
    ck_s2_r <= ck_s1_r;
  end
  always @*
  begin
    f_in_valid = 1'b0;
    f_in_data = {KIND_ADD, add_s2_r};
    case (mode_sel)
      KIND_ADD:
      begin
        f_in_valid = add_fall;
      end
      KIND_HDLC:
      begin
        f_in_valid = hdlc_rise;
        f_in_data = {KIND_HDLC, hd_s2_r};
      end
      KIND_SERIAL:
      begin
        // The bit counter passes skipped overhead bits untouched, so a word may straddle overhead.
        // eight serial bits form a word
        f_in_valid = pay_rise & ~oh_skip_r & (ser_cnt_r == 3'h7);
        f_in_data = {KIND_SERIAL, ser_nxt};
      end
      default:
      begin
        f_in_valid = 1'b0;
      end
    endcase
  end
  always @(posedge clk_in)
  begin
    if (reset_in)
    begin
      ck_prev_r <= 2'h0;
      div_r <= 8'h00;
      hdlc_tx_byte_clock_ch2_out <= 1'b0;
      oh_cnt_r <= 8'h00;
      ser_sh_r <= 8'h00;
      ser_cnt_r <= 3'h0;
      oh_skip_r <= 1'b0;
      overhead_warn_out <= 1'b0;
    end
    else
    begin
      ck_prev_r <= ck_s2_r;
      // Stalling the divider while the clock is low holds back the next rising edge, so a full
      // buffer never loses an HDLC byte; the add bus and the serial input cannot be throttled
      // and drop words instead.
      // byte clock divider, held while the clock is low and the buffer is full
      if (mode_sel == KIND_HDLC && (f_in_ready || hdlc_tx_byte_clock_ch2_out))
      begin
        if (div_r == HDLC_HALF - 8'h01)
        begin
          div_r <= 8'h00;
          hdlc_tx_byte_clock_ch2_out <= ~hdlc_tx_byte_clock_ch2_out;
        end
        else
        begin
          div_r <= div_r + 8'h01;
        end
      end
      else if (mode_sel != KIND_HDLC)
      begin
        div_r <= 8'h00;
        hdlc_tx_byte_clock_ch2_out <= 1'b0;
      end
      if (mode_sel == KIND_SERIAL && pay_rise)
      begin
        // The warning is raised two bits ahead of the overhead bit, so it stands for the whole
        // bit period just before it.
        // warn ahead, then skip the overhead bit
        oh_cnt_r <= (oh_cnt_r == OH_PERIOD - 8'h01) ? 8'h00 : oh_cnt_r + 8'h01;
        overhead_warn_out <= (oh_cnt_r == OH_PERIOD - 8'h03);
        oh_skip_r <= (oh_cnt_r == OH_PERIOD - 8'h02);
        if (!oh_skip_r)
        begin
          ser_sh_r <= ser_nxt;
          ser_cnt_r <= ser_cnt_r + 3'h1;
        end
      end
      else if (mode_sel != KIND_SERIAL)
      begin
        oh_cnt_r <= 8'h00;
        ser_cnt_r <= 3'h0;
        oh_skip_r <= 1'b0;
        overhead_warn_out <= 1'b0;
      end
    end
  end
  // The buffer is ten bits wide so that the kind code travels with its byte.
  txmux_fifo #(
    .WIDTH(10),
    .DEPTH(`TXMUX_FIFO_DEPTH),
    .AW(`TXMUX_FIFO_AW)
  ) u_fifo (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .in_valid_in(f_in_valid),
    .in_ready_out(f_in_ready),
    .in_data_in(f_in_data),
    .out_valid_out(f_out_valid),
    .out_ready_in(data_ready_in & ~data_valid_out),
    .out_data_out(f_out_data)
  );
  // Registered output stage; one word per handshake, ready seen while valid is low.
  // Valid drops for at least one cycle between words, so a consumer never takes a word twice.
  always @(posedge clk_in)
  begin
    if (reset_in)
    begin
      data_valid_out <= 1'b0;
      data_kind_out <= 2'h0;
      data_byte_out <= 8'h00;
    end
    else if (data_valid_out)
    begin
      data_valid_out <= 1'b0;
    end
    else if (f_out_valid && data_ready_in)
    begin
      data_valid_out <= 1'b1;
      data_kind_out <= f_out_data[9:8];
      data_byte_out <= f_out_data[7:0];
    end
  end
endmodule // txmux_top
`default_nettype wire

// >>> testbench/txmux_asserts.sv
`default_nettype none
module txmux_chk (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic add_bus_enable_in,
  input wire logic clear_mode_in,
  input wire logic add_bus_ch2_clock,
  input wire logic data_ready_in,
  input wire logic hdlc_tx_byte_clock_ch2_out,
  input wire logic overhead_warn_out,
  input wire logic data_valid_out,
  input wire logic [1:0] data_kind_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  add_kind_a: assert property (data_valid_out && add_bus_enable_in |-> data_kind_out == 2'h0)
    else $error("add kind");
  add_take_a: assert property ($fell(add_bus_ch2_clock) && add_bus_enable_in && data_ready_in
    |-> ##[2:7] data_valid_out) else $error("add word late");
  hdlc_kind_a: assert property (data_valid_out && !add_bus_enable_in && !clear_mode_in
    |-> data_kind_out == 2'h1) else $error("hdlc kind");
  clk_rate_a: assert property ($rose(hdlc_tx_byte_clock_ch2_out)
    |-> hdlc_tx_byte_clock_ch2_out[*4] ##1 !hdlc_tx_byte_clock_ch2_out) else $error("byte clock");
  hdlc_take_a: assert property ($rose(hdlc_tx_byte_clock_ch2_out) && data_ready_in
    |-> ##[1:6] data_valid_out) else $error("hdlc word late");
  ser_kind_a: assert property (data_valid_out && !add_bus_enable_in && clear_mode_in
    |-> data_kind_out == 2'h2) else $error("serial kind");
  warn_len_a: assert property ($rose(overhead_warn_out)
    |-> overhead_warn_out[*7] ##[1:3] !overhead_warn_out) else $error("warn length");
  cover property (data_valid_out && data_kind_out == 2'h0);
  cover property (data_valid_out && data_kind_out == 2'h1);
  cover property ($rose(overhead_warn_out));
endmodule // txmux_chk
bind txmux_top txmux_chk chk_u (
  .clk_in(clk_in),
  .reset_in(reset_in),
  .add_bus_enable_in(add_bus_enable_in),
  .clear_mode_in(clear_mode_in),
  .add_bus_ch2_clock(add_bus_ch2_clock),
  .data_ready_in(data_ready_in),
  .hdlc_tx_byte_clock_ch2_out(hdlc_tx_byte_clock_ch2_out),
  .overhead_warn_out(overhead_warn_out),
  .data_valid_out(data_valid_out),
  .data_kind_out(data_kind_out)
);
`default_nettype wire

// >>> testbench/txmux_term.sv
`default_nettype none
module txmux_term (
  input wire logic reset_in,
  input wire logic ser_en_in,
  input wire logic [7:0] word_in,
  input wire logic hdlc_tx_byte_clock_ch2_out,
  input wire logic overhead_warn_out,
  output logic payload_in_clock,
  output logic [7:0] add_bus_ch2_in,
  output logic [7:0] hdlc_tx_byte_ch2_in
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] stream_pat = 32'hB3C596E1;
  logic [4:0] idx_r = 5'h00;
  logic skip_r = 1'b0;
  logic [7:0] cnt_r = 8'h00;
  initial payload_in_clock = 1'b0;
  // The serial clock stands low outside a frame.
  always #200 payload_in_clock = ser_en_in & ~payload_in_clock;
  // serial payload stream
  // A warning seen at a falling edge marks the next bit as the last before overhead,
  // so the stream stands still for the bit after that one.
  // withhold payload over overhead
  always @(negedge payload_in_clock or negedge ser_en_in)
  begin
    if (!ser_en_in)
      idx_r <= 5'h00;
    else if (!skip_r)
      idx_r <= idx_r + 5'h01;
    skip_r <= ser_en_in & overhead_warn_out;
  end
  assign add_bus_ch2_in = ser_en_in ? {word_in[7], stream_pat[5'h1F - idx_r], word_in[5:0]} : word_in;
  always @(negedge hdlc_tx_byte_clock_ch2_out or posedge reset_in) cnt_r <= reset_in ? 8'h00 : cnt_r + 8'h01;
  assign hdlc_tx_byte_ch2_in = 8'h40 + cnt_r;
endmodule // txmux_term
`default_nettype wire

// >>> testbench/tx_ch2_bit6_input_mux_tb.sv
`default_nettype none
module tx_ch2_bit6_input_mux_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0, reset_in = 1'b1, add_bus_enable_in = 1'b0, clear_mode_in = 1'b0;
  logic add_bus_ch2_clock = 1'b0, data_ready_in = 1'b1, ser_en_in = 1'b0, payload_in_clock;
  logic hdlc_tx_byte_clock_ch2_out, overhead_warn_out, data_valid_out;
  logic [1:0] data_kind_out;
  logic [7:0] word_in = 8'h00, data_byte_out, add_bus_ch2_in, hdlc_tx_byte_ch2_in;
  integer failures = 0, checks_done = 0, i;
  always #25 clk_in = ~clk_in;
  txmux_top #(
    .OH_PERIOD(8'h10),
    .HDLC_HALF(8'h04)
  ) dut_u (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .add_bus_enable_in(add_bus_enable_in),
    .clear_mode_in(clear_mode_in),
    .add_bus_ch2_clock(add_bus_ch2_clock),
    .add_bus_ch2_in(add_bus_ch2_in),
    .hdlc_tx_byte_ch2_in(hdlc_tx_byte_ch2_in),
    .payload_in_clock(payload_in_clock),
    .data_ready_in(data_ready_in),
    .hdlc_tx_byte_clock_ch2_out(hdlc_tx_byte_clock_ch2_out),
    .overhead_warn_out(overhead_warn_out),
    .data_valid_out(data_valid_out),
    .data_kind_out(data_kind_out),
    .data_byte_out(data_byte_out)
  );
  txmux_term term_u (
    .reset_in(reset_in),
    .ser_en_in(ser_en_in),
    .word_in(word_in),
    .hdlc_tx_byte_clock_ch2_out(hdlc_tx_byte_clock_ch2_out),
    .overhead_warn_out(overhead_warn_out),
    .payload_in_clock(payload_in_clock),
    .add_bus_ch2_in(add_bus_ch2_in),
    .hdlc_tx_byte_ch2_in(hdlc_tx_byte_ch2_in)
  );
  task automatic summarize;
    $display("failures %0d checks %0d", failures, checks_done);
    if (failures == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic start(input logic add_en, input logic clear);
    reset_in = 1'b1;
    add_bus_enable_in = add_en;
    clear_mode_in = clear;
    repeat (6) @(negedge clk_in);
    reset_in = 1'b0;
    repeat (3) @(negedge clk_in);
  endtask
  task automatic expect_word(input logic [1:0] k, input logic [7:0] b);
    for (int n = 0; n < 200 && data_valid_out !== 1'b1; n++)
      @(negedge clk_in);
    checks_done++;
    if (data_valid_out !== 1'b1 || data_kind_out !== k || data_byte_out !== b)
    begin
      failures++;
      $display("BAD %0t got %h %h want %h %h", $time, data_kind_out, data_byte_out, k, b);
    end
    @(negedge clk_in);
  endtask
  task automatic send_add(input logic [7:0] w);
    word_in = w;
    add_bus_ch2_clock = 1'b1;
    repeat (4) @(negedge clk_in);
    add_bus_ch2_clock = 1'b0;
    @(negedge clk_in);
  endtask
  // Clear mode set too: the add bus must still win.
  task automatic t_add;
    start(1'b1, 1'b1);
    for (i = 0; i < 3; i++)
    begin
      send_add(8'h40 ^ {8{i[0]}});
      expect_word(2'h0, 8'h40 ^ {8{i[0]}});
    end
  endtask
  task automatic t_fill;
    start(1'b1, 1'b0);
    data_ready_in = 1'b0;
    for (i = 0; i < 6; i++)
      send_add(8'h10 + i);
    // Let the sixth word meet the full buffer before the consumer starts draining it.
    repeat (4) @(negedge clk_in);
    data_ready_in = 1'b1;
    for (i = 0; i < 4; i++)
      expect_word(2'h0, 8'h10 + i);
    i = 0;
    repeat (20) @(negedge clk_in) i += data_valid_out;
    checks_done++;
    if (i !== 0)
    begin
      failures++;
      $display("BAD %0t word kept past full", $time);
    end
  endtask
  task automatic t_hdlc;
    start(1'b0, 1'b0);
    for (i = 0; i < 3; i++)
      expect_word(2'h1, 8'h40 + i);
  endtask
  task automatic t_serial;
    start(1'b0, 1'b1);
    ser_en_in = 1'b1;
    expect_word(2'h2, 8'hB3);
    expect_word(2'h2, 8'hC5);
    ser_en_in = 1'b0;
  endtask
  initial
  begin
    t_add();
    t_fill();
    t_hdlc();
    t_serial();
    summarize();
  end
  initial
  begin
    #200000;
    failures++;
    summarize();
  end
endmodule // tx_ch2_bit6_input_mux_tb
`default_nettype wire
